// ---- chain_pkg.sv ----
package chain_pkg;
   // channel count and select code layout
   localparam int          NCH          = 8;
   localparam logic [5:0]  FIRST_CODE   = 6'h04;  // power-fail channel
   localparam logic [5:0]  SYS_CODE     = 6'h00;  // system enable target
   localparam int          FREE_CHANS   = 2;      // channels 0,1 ignore system enable
   localparam logic [1:0]  MAX_INDIRECT = 2'h3;
   // register byte offsets
   localparam logic [3:0]  OFF_STATUS   = 4'h0;
   localparam logic [3:0]  OFF_MASK     = 4'h4;
   localparam logic [3:0]  OFF_STATE    = 4'h8;
   localparam logic [1:0]  EVT_W        = 2'h2;
   localparam int          EV_REQUEST   = 0;
   localparam int          EV_ACK       = 1;
   // reset values
   localparam logic        RST_ENABLE   = 1'b0;
   localparam logic        RST_CONTROL  = 1'b0;
   localparam logic        RST_FLAG     = 1'b1;
   localparam logic [1:0]  RST_MASK     = 2'h0;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // central machine-cycle strobes, one cycle each
   typedef struct packed {
      logic flag_enable_strobe;      // T2
      logic interrupt_enable_strobe; // T3
      logic t4;
      logic set_request_strobe;      // T5
      logic t6;
   } io_timing_t;

   // decoded i/o group instruction
   typedef struct packed {
      logic       io_group_strobe;
      logic       set_control_instr;
      logic       clear_control_instr;
      logic       set_flag_instr;
      logic       clear_flag_instr;
      logic [2:0] select_code_high_digit;
      logic [2:0] select_code_low_digit;
   } io_instr_t;

   typedef enum logic [2:0] {
      RD_IDLE = 3'b001,
      RD_RESP = 3'b010,
      RD_HOLD = 3'b100
   } rd_state_t;
endpackage : chain_pkg

// ---- chain_intr.sv ----
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module chain_intr (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire chain_pkg::io_timing_t  timing,
   input  wire chain_pkg::io_instr_t   instr,
   input  wire logic [7:0]             device_flag,
   input  wire logic [7:0]             slot_present,
   input  wire logic                   jump_indirect,
   input  wire logic                   jump_subroutine_indirect,
   input  wire logic                   indirect_ref,
   input  wire logic                   phase_end,
   input  wire logic                   fetch_phase,
   output logic                        phase_interrupt_request,
   output logic                        grant_fetch,
   output logic                        interrupt_acknowledge,
   output logic [5:0]                  service_addr,
   output logic [7:0]                  priority_out,
   output logic                        irq,
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [3:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import chain_pkg::*;

   function automatic logic code_hit(input io_instr_t i, input logic [5:0] code);
      code_hit = i.io_group_strobe && i.select_code_high_digit == code[5:3]
                 && i.select_code_low_digit == code[2:0];
   endfunction : code_hit

   logic [NCH-1:0] control;
   logic [NCH-1:0] flag_buf;
   logic [NCH-1:0] flag_ff;
   logic [NCH-1:0] qual;
   logic [NCH-1:0] request_ff;
   logic [NCH-1:0] priority_in;
   logic [NCH-1:0] local_req;
   logic [NCH-1:0] set_req;
   logic [NCH-1:0] sel;
   logic           sys_enable;
   logic           intr_control;
   logic           pending_n, pend_set;
   logic [1:0]     ind_cnt;
   logic           jump_block;
   logic           prio_instr;
   logic [5:0]     winner_code;
   logic [EVT_W-1:0] status;
   logic [EVT_W-1:0] mask;
   logic [EVT_W-1:0] events;

   assign prio_instr = instr.io_group_strobe && (instr.set_control_instr
                       || instr.clear_control_instr || instr.set_flag_instr
                       || instr.clear_flag_instr);

   // per-channel cards; even channel is a slot's output part, odd its input part
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_card
         localparam logic [5:0] CODE = FIRST_CODE + 6'(g);
         localparam logic       FREE = (g < FREE_CHANS);
         assign sel[g] = code_hit(instr, CODE);
         // chain link: output part (even) feeds input part (odd) inside a slot
         if (g == 0) begin : g_head
            assign priority_in[g] = 1'b1;
         end else begin : g_link
            assign priority_in[g] = priority_out[g-1];
         end
         assign local_req[g]    = slot_present[g] && flag_ff[g] && qual[g];
         // an empty position just forwards the chain
         assign priority_out[g] = priority_in[g] && !local_req[g];
         assign set_req[g]      = local_req[g] && priority_in[g]
                                  && timing.set_request_strobe && flag_buf[g];

         // control flip-flop
         always_ff @(posedge aclk) begin
            if (!aresetn)
               control[g] <= RST_CONTROL;
            else if (timing.t4 && sel[g] && instr.set_control_instr)
               control[g] <= 1'b1;
            else if (timing.t4 && sel[g] && instr.clear_control_instr)
               control[g] <= 1'b0;
         end

         // qualifier sampled on the T3 strobe, dropped with control
         always_ff @(posedge aclk) begin
            if (!aresetn)
               qual[g] <= 1'b0;
            else if (!control[g])
               qual[g] <= 1'b0;
            else if (timing.interrupt_enable_strobe)
               qual[g] <= FREE || sys_enable;
         end

         // flag buffer: device set wins over a same-cycle clear
         always_ff @(posedge aclk) begin
            if (!aresetn)
               flag_buf[g] <= RST_FLAG;
            else if (device_flag[g] || (sel[g] && instr.set_flag_instr))
               flag_buf[g] <= 1'b1;
            else if (interrupt_acknowledge && request_ff[g])
               flag_buf[g] <= 1'b0;
            else if (sel[g] && instr.clear_flag_instr)
               flag_buf[g] <= 1'b0;
         end

         // flag flip-flop set from the buffer at T2, cleared only by a clear-flag instruction
         always_ff @(posedge aclk) begin
            if (!aresetn)
               flag_ff[g] <= RST_FLAG;
            else if ((timing.flag_enable_strobe && flag_buf[g])
                     || (sel[g] && instr.set_flag_instr))
               flag_ff[g] <= 1'b1;
            else if (sel[g] && instr.clear_flag_instr)
               flag_ff[g] <= 1'b0;
         end

         // request released each T2 so a higher card can claim the chain
         always_ff @(posedge aclk) begin
            if (!aresetn)
               request_ff[g] <= 1'b0;
            else if (timing.flag_enable_strobe)
               request_ff[g] <= 1'b0;
            else if (set_req[g])
               request_ff[g] <= 1'b1;
         end

         a_req_needs_chain: assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(request_ff[g]) |-> $past(priority_in[g] && flag_buf[g]
               && timing.set_request_strobe))
            else $error("request set without chain or buffer");
         a_block_lower: assert property (@(posedge aclk) disable iff (!aresetn)
            local_req[g] |-> !priority_out[g] && !priority_out[NCH-1])
            else $error("requesting card left chain open");
         a_ack_clears_buf: assert property (@(posedge aclk) disable iff (!aresetn)
            interrupt_acknowledge && request_ff[g] && !device_flag[g]
            && !(sel[g] && instr.set_flag_instr) |=> !flag_buf[g])
            else $error("acknowledge did not clear flag buffer");
         a_ctrl_t4_only: assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(control[g]) |-> $past(timing.t4 && sel[g]
               && instr.set_control_instr))
            else $error("control set outside T4 match");
      end
   endgenerate

   // lowest channel holding a request has the chain; nesting needs no extra state
   always_comb begin
      winner_code = FIRST_CODE;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (request_ff[i])
            winner_code = FIRST_CODE + 6'(i);
      end
   end

   // system enable via flag instructions to code 00
   always_ff @(posedge aclk) begin
      if (!aresetn)
         sys_enable <= RST_ENABLE;
      else if (code_hit(instr, SYS_CODE) && instr.set_flag_instr)
         sys_enable <= 1'b1;
      else if (code_hit(instr, SYS_CODE) && instr.clear_flag_instr)
         sys_enable <= 1'b0;
   end

   // interrupt control: cleared by priority instructions, reset at next T2
   always_ff @(posedge aclk) begin
      if (!aresetn)
         intr_control <= 1'b1;
      else if (prio_instr)
         intr_control <= 1'b0;
      else if (timing.flag_enable_strobe)
         intr_control <= 1'b1;
   end

   // pending request, active low; forced idle while control is clear
   assign pend_set = intr_control && !prio_instr && !fetch_phase && |set_req
                     && (sys_enable || |set_req[FREE_CHANS-1:0]);
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pending_n <= 1'b1;
      else if (!intr_control || prio_instr || fetch_phase)
         pending_n <= 1'b1;
      else if (pend_set)
         pending_n <= 1'b0;
   end
   assign phase_interrupt_request = !pending_n;

   // indirect-level counter for jump blocking
   always_ff @(posedge aclk) begin
      if (!aresetn)
         ind_cnt <= 2'h0;
      else if (!(jump_indirect || jump_subroutine_indirect))
         ind_cnt <= 2'h0;
      else if (indirect_ref && ind_cnt != MAX_INDIRECT)
         ind_cnt <= ind_cnt + 2'h1;
   end
   // after the third level the jump no longer holds off the interrupt
   assign jump_block  = (jump_indirect || jump_subroutine_indirect)
                        && ind_cnt != MAX_INDIRECT;
   assign grant_fetch = phase_end && !pending_n && !jump_block;
   assign interrupt_acknowledge = fetch_phase && timing.t6;

   // service address captured at T6 of the fetch phase
   always_ff @(posedge aclk) begin
      if (!aresetn)
         service_addr <= 6'h00;
      else if (interrupt_acknowledge)
         service_addr <= winner_code;
   end

   // sticky events, mask, level interrupt
   assign events[EV_REQUEST] = pending_n && pend_set;  // pending about to go active
   assign events[EV_ACK]     = interrupt_acknowledge;
   assign irq = |(status & mask);

   // ---- axi4-lite slave ----
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   rd_state_t   rd_state;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = rd_state == RD_IDLE;

   // write side: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         mask         <= RST_MASK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == OFF_MASK) begin
               s_axi_bresp <= RESP_OKAY;
               if (w_strb[0])
                  mask <= w_data[EVT_W-1:0];
            end else if (aw_addr == OFF_STATUS || aw_addr == OFF_STATE)
               s_axi_bresp <= RESP_OKAY;  // read-only, write ignored
            else
               s_axi_bresp <= RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read side: one cycle to data, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state     <= RD_IDLE;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         case (rd_state)
            RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state     <= RD_HOLD;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp  <= RESP_OKAY;
                  if (s_axi_araddr == OFF_STATUS)
                     s_axi_rdata <= {30'h0, status};
                  else if (s_axi_araddr == OFF_MASK)
                     s_axi_rdata <= {30'h0, mask};
                  else if (s_axi_araddr == OFF_STATE)
                     s_axi_rdata <= {8'h0, qual, control, service_addr,
                                     sys_enable, intr_control};
                  else begin
                     s_axi_rdata <= 32'h0;
                     s_axi_rresp <= RESP_SLVERR;
                  end
               end
            end
            RD_HOLD: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_state     <= RD_IDLE;
               end
            end
            default: rd_state <= RD_IDLE;
         endcase
      end
   end

   // status clears at the edge its read is taken, so nothing folded in is lost; events win
   always_ff @(posedge aclk) begin
      if (!aresetn)
         status <= 2'h0;
      else
         status <= (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STATUS
                    ? 2'h0 : status) | events;
   end

   a_free_chan_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      control[0] && timing.interrupt_enable_strobe |=> qual[0])
      else $error("power-fail qualifier blocked by system enable");
   a_ctrl_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      prio_instr |=> !intr_control && pending_n)
      else $error("priority instruction failed to clear control");
   a_pending_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(pending_n) |-> $past(intr_control && timing.set_request_strobe
         && |set_req))
      else $error("pending cleared without all terms");
   a_jump_block: assert property (@(posedge aclk) disable iff (!aresetn)
      jump_block |-> !grant_fetch)
      else $error("fetch granted during indirect jump");
   sequence s_enable_cmd;
      code_hit(instr, SYS_CODE) && instr.set_flag_instr && !instr.clear_flag_instr;
   endsequence
   a_sys_enable_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_enable_cmd |=> sys_enable ##0 (sys_enable || instr.clear_flag_instr))
      else $error("system enable not set");
   a_addr_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      interrupt_acknowledge && |request_ff |=> service_addr == $past(winner_code))
      else $error("service address not captured");
endmodule : chain_intr
`default_nettype wire

// ---- phase_timing_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module phase_timing_model (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 slow,
   input  wire logic                 grant_fetch,
   output var chain_pkg::io_timing_t timing,
   output logic                      phase_end,
   output logic                      fetch_phase
);
   import chain_pkg::*;
   logic [2:0] cnt;
   logic [2:0] last;
   // slow mode adds two idle states ahead of the strobes
   assign last = slow ? 3'd7 : 3'd5;
   // strobes keep their order, t6 always closes the machine phase
   assign timing = {cnt == last - 3'd4, cnt == last - 3'd3, cnt == last - 3'd2,
                    cnt == last - 3'd1, cnt == last};
   assign phase_end = (cnt == last);
   // fetch phase lasts one whole machine cycle after a grant
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 3'd0;
         fetch_phase <= 1'b0;
      end else begin
         cnt <= (cnt >= last) ? 3'd0 : cnt + 3'd1; // wraps safely if slow drops
         if (grant_fetch) begin
            fetch_phase <= 1'b1;
         end else if (phase_end) begin
            fetch_phase <= 1'b0;
         end
      end
   end
endmodule : phase_timing_model
`default_nettype wire

// ---- daisy_chain_interrupt_priority_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_interrupt_priority_tb_top;
   import chain_pkg::*;
   localparam logic [3:0] SET_CTL = 4'h8;
   localparam logic [3:0] SET_FLG = 4'h2;
   localparam logic [3:0] CLR_FLG = 4'h1;
   logic        aclk, aresetn, slow, jump_indirect, jump_subroutine_indirect, indirect_ref;
   logic        phase_end, fetch_phase, phase_interrupt_request, grant_fetch;
   logic        interrupt_acknowledge, irq;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rnd;
   logic [5:0]  service_addr;
   logic [7:0]  device_flag, slot_present, priority_out;
   logic [65:0] exp_q[$];
   io_timing_t  timing;
   io_instr_t   instr;
   int          n_mismatch, compares;

   chain_intr chain_intr_i (
      .aclk(aclk), .aresetn(aresetn), .timing(timing), .instr(instr),
      .device_flag(device_flag), .slot_present(slot_present),
      .jump_indirect(jump_indirect), .jump_subroutine_indirect(jump_subroutine_indirect),
      .indirect_ref(indirect_ref), .phase_end(phase_end), .fetch_phase(fetch_phase),
      .phase_interrupt_request(phase_interrupt_request), .grant_fetch(grant_fetch),
      .interrupt_acknowledge(interrupt_acknowledge), .service_addr(service_addr),
      .priority_out(priority_out), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   phase_timing_model phase_timing_model_i (
      .aclk(aclk), .aresetn(aresetn), .slow(slow), .grant_fetch(grant_fetch),
      .timing(timing), .phase_end(phase_end), .fetch_phase(fetch_phase));

   // single verdict point for normal end and timeouts
   task close_out();
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [33:0] got, input logic [33:0] want);
      compares++;
      if (got !== want) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk

   task automatic fail_wait();
      n_mismatch++;
      close_out();
   endtask : fail_wait

   // wait for strobe b of the machine cycle, optionally with a pending request
   task automatic wt(input int b, input logic p);
      for (int k = 0; k < 200; k++) begin
         @(posedge aclk);
         #1;
         if (timing[b] && (!p || phase_interrupt_request)) return;
      end
      fail_wait();
   endtask : wt

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk(34'(bresp), 34'(r));
            return;
         end
      end
      fail_wait();
   endtask : wr

   // expected read result is noted first, the watcher compares it
   task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [31:0] m);
      exp_q.push_back({m, e[33:32], e[31:0] & m});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            return;
         end
      end
      fail_wait();
   endtask : rd

   // i/o group instruction issued in the t4 slot
   task automatic io(input logic [3:0] op, input logic [5:0] code);
      wt(3, 1'b0);
      @(posedge aclk);
      instr <= {1'b1, op, code};
      @(posedge aclk);
      instr <= '0;
   endtask : io

   task automatic pulse_flag(input logic [7:0] m);
      @(posedge aclk);
      device_flag <= m;
      @(posedge aclk);
      device_flag <= '0;
   endtask : pulse_flag

   // grant at phase end, then acknowledge and address in the fetch phase
   task automatic serve(input logic [5:0] c);
      chk(34'(grant_fetch), 34'h1);
      wt(0, 1'b0);
      chk(34'({fetch_phase, interrupt_acknowledge}), 34'h3);
      rd(OFF_STATE, {RESP_OKAY, 24'h0, c, 2'b00}, 32'h0000_00fc);
      chk(34'(service_addr), 34'(c));
   endtask : serve

   // read data matched when the handshake completes
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         chk({rresp, rdata & exp_q[0][65:34]}, exp_q[0][33:0]);
         void'(exp_q.pop_front());
      end
   end

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   initial begin
      {aresetn, slow, jump_indirect, jump_subroutine_indirect, indirect_ref} = '0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      instr = '0;
      device_flag = '0;
      n_mismatch = 0;
      compares = 0;
      rnd = $urandom(5);
      slot_present = rnd[7:0];
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_STATUS, {RESP_OKAY, 32'h0}, '1);
      rd(OFF_MASK, {RESP_OKAY, 32'h0}, '1);
      rd(OFF_STATE, {RESP_OKAY, 32'h0}, 32'hffff_fffe);
      rd(4'hc, {RESP_SLVERR, 32'h0}, '1);
      rnd = $urandom;
      wr(4'hc, rnd, RESP_SLVERR);
      wr(OFF_MASK, {rnd[31:2], 2'b11}, RESP_OKAY);
      rd(OFF_MASK, {RESP_OKAY, 32'h3}, '1);
      chk(34'(priority_out), 34'hff);
      slot_present <= 8'h1f | rnd[15:8];
      io(SET_FLG, SYS_CODE);
      io(CLR_FLG, FIRST_CODE + 6'd2);
      io(CLR_FLG, FIRST_CODE + 6'd3);
      io(SET_CTL, FIRST_CODE + 6'd2);
      io(SET_CTL, FIRST_CODE + 6'd3);
      rd(OFF_STATE, {RESP_OKAY, 32'h0000_0c02}, 32'h0000_ff02);
      pulse_flag(8'h0c);
      wt(0, 1'b1);
      serve(FIRST_CODE + 6'd2);
      chk(34'(irq), 34'h1);
      rd(OFF_STATUS, {RESP_OKAY, 32'h3}, '1);
      rd(OFF_STATUS, {RESP_OKAY, 32'h0}, '1);
      wt(0, 1'b0);
      chk(34'(irq), 34'h0);
      chk(34'(phase_interrupt_request), 34'h0);
      chk(34'(priority_out), 34'h03);
      io(CLR_FLG, FIRST_CODE + 6'd2);
      wt(0, 1'b0);
      chk(34'(phase_interrupt_request), 34'h0);
      wt(0, 1'b1);
      serve(FIRST_CODE + 6'd3);
      // both indirect jump kinds hold off the grant until the third level
      io(CLR_FLG, FIRST_CODE + 6'd3);
      io(SET_CTL, FIRST_CODE + 6'd4);
      for (int j = 0; j < 2; j++) begin
         io(CLR_FLG, FIRST_CODE + 6'd4);
         jump_indirect <= (j == 0);
         jump_subroutine_indirect <= (j == 1);
         pulse_flag(8'h10);
         wt(0, 1'b1);
         chk(34'(grant_fetch), 34'h0);
         repeat (3) begin
            @(posedge aclk);
            indirect_ref <= 1'b1;
            @(posedge aclk);
            indirect_ref <= 1'b0;
         end
         // third level lands in the phase's last cycle, so the grant is due right now
         #1;
         serve(FIRST_CODE + 6'd4);
         jump_indirect <= 1'b0;
         jump_subroutine_indirect <= 1'b0;
      end
      // system disabled, slow cycles: only the power-fail channel gets through
      io(CLR_FLG, SYS_CODE);
      rd(OFF_STATE, {RESP_OKAY, 32'h0}, 32'h2);
      wr(OFF_MASK, 32'h2, RESP_OKAY);
      rd(OFF_STATUS, {RESP_OKAY, 32'h0}, 32'h0);
      slow <= 1'b1;
      io(CLR_FLG, FIRST_CODE);
      io(SET_CTL, FIRST_CODE);
      pulse_flag(8'h11);
      wt(0, 1'b1);
      chk(34'(irq), 34'h0);
      serve(FIRST_CODE);
      chk(34'(irq), 34'h1);
      io(CLR_FLG, FIRST_CODE);
      wt(0, 1'b0);
      wt(0, 1'b0);
      chk(34'(phase_interrupt_request), 34'h0);
      close_out();
   end
endmodule : daisy_chain_interrupt_priority_tb_top
`default_nettype wire
